// ### hw/lpti_defines.svh
// constants for the light and proximity threshold interrupt block
// assumes inclusion by both design files
`ifndef LPTI_DEFINES_SVH
`define LPTI_DEFINES_SVH
`define LPTI_ADDR_INT_CFG 8'h19
`define LPTI_ADDR_PERSIST 8'h1a
`define LPTI_ADDR_UP_LO 8'h1b
`define LPTI_ADDR_UP_HI 8'h1c
`define LPTI_ADDR_LOW_LO 8'h1d
`define LPTI_ADDR_LOW_HI 8'h1e
`define LPTI_ADDR_OFS_LO 8'h1f
`define LPTI_ADDR_OFS_HI 8'h20
`define LPTI_CFG_PROX_EN 0
`define LPTI_CFG_OUT_MODE 1
`define LPTI_CFG_AMB_EN 2
`define LPTI_CFG_RSVD 3
`define LPTI_CFG_SRC_LSB 4
`define LPTI_CFG_SRC_MSB 5
`define LPTI_PERSIST_AMB_MSB 7
`define LPTI_PERSIST_AMB_LSB 4
`define LPTI_PERSIST_PROX_MSB 3
`define LPTI_PERSIST_PROX_LSB 0
`define LPTI_HI_MSB 2
`define LPTI_RST_INT_CFG 8'h10
`define LPTI_RST_PERSIST 8'h00
`define LPTI_RST_UP_LO 8'hff
`define LPTI_RST_UP_HI 8'h07
`define LPTI_RST_LOW_LO 8'h00
`define LPTI_RST_LOW_HI 8'h00
`define LPTI_RST_OFS_LO 8'h00
`define LPTI_RST_OFS_HI 8'h00
`endif

// ### hw/lpti_pkg.sv
// types shared by the threshold interrupt block
// assumes nothing beyond the defines header
package lpti_pkg;
  typedef logic [7:0] lpti_byte_t;
  typedef enum logic {LPTI_MODE_LATCHED, LPTI_MODE_LOGIC} lpti_out_mode_t;
endpackage

// ### hw/lpti_persist.sv
// consecutive out-of-window counter for one channel
// assumes sample is a one-cycle pulse per finished measurement
`timescale 1ns/1ns
`include "lpti_defines.svh"
module lpti_persist
  import lpti_pkg::*;
#(
  parameter int CNT_WIDTH = 4
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic sample,
  input wire logic outside,
  input wire logic [CNT_WIDTH-1:0] limit,
  output logic fire
);
  logic [CNT_WIDTH-1:0] count;
  logic [CNT_WIDTH-1:0] next_count;

  // elaboration check on the counter width
  if (CNT_WIDTH < 1 || CNT_WIDTH > 8)
  begin
    $error("lpti_persist: CNT_WIDTH out of range");
  end

  // fire when this sample makes limit+1 or more in a row
  assign fire = sample && outside && (count >= limit); // R04 R05 R06

  always_comb
  begin
    next_count = count;
    if (sample)
    begin
      if (!outside)
        next_count = '0; // R17
      else if (count < limit)
        next_count = count + {{(CNT_WIDTH-1){1'b0}}, 1'b1}; // R04
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      count <= '0;
    else if (clkEn)
      count <= next_count;
  end
endmodule

// ### hw/lpti_top.sv
// threshold interrupt logic of the light and proximity sensor
// assumes a register port decoded by the serial slave and measurement strobes
// Operation
// R01 - ambient interrupt reaches the pin only while ambient enable bit 2 is set
// R02 - latched mode: pin stays active after an event until status is read
// R03 - logic mode: pin updated after each measurement, held until the next
// R04 - interrupt only after programmed count of consecutive out-of-window values
// R05 - ambient persistence bits 7:4, count is field plus one
// R06 - proximity persistence bits 3:0, same encoding
// R07 - proximity condition when result above upper or below lower limit
// R08 - upper limit is 11 bits, resets to all ones, unused bits read zero
// R09 - lower limit is 11 bits, resets to zero
// R10 - crosstalk offset subtracted from raw value before storing result
// R11 - offset is 11 bits from low byte and bits 2:0 high, resets zero
// R12 - interrupt outputs are active low
// R13 - proximity interrupt gated by enable bit 0; in logic mode the pin follows proxLogic without bit 0
// R14 - status read clears latched flags and releases the pin; in logic mode the pin holds until the next measurement
// R15 - logic signal 0 below lower limit, 1 above upper, else held
// R16 - host keeps source field at 01 and reserved bit 3 at 0
// R17 - counters restart inside window; subtraction clamps at zero
`timescale 1ns/1ns
`include "lpti_defines.svh"
module lpti_top
  import lpti_pkg::*;
#(
  parameter int PROX_WIDTH = 11,
  parameter int PERSIST_WIDTH = 4
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire logic statusRead,
  input wire logic proxRawValid,
  input wire logic [PROX_WIDTH-1:0] proxRaw,
  input wire logic ambientValid,
  input wire logic ambientOutside,
  output logic proxResultValid,
  output logic [PROX_WIDTH-1:0] proxResult,
  output logic proxLogic,
  output logic ambientIntFlag,
  output logic proxIntFlag,
  output logic ambientIntN,
  output logic proxIntN,
  output logic intPinN
);
  lpti_byte_t intCfg, next_intCfg;
  lpti_byte_t persist, next_persist;
  lpti_byte_t upLo, next_upLo;
  lpti_byte_t upHi, next_upHi;
  lpti_byte_t lowLo, next_lowLo;
  lpti_byte_t lowHi, next_lowHi;
  lpti_byte_t ofsLo, next_ofsLo;
  lpti_byte_t ofsHi, next_ofsHi;
  lpti_byte_t next_regRdData;
  logic [PROX_WIDTH-1:0] upLimit, lowLimit, offset, corrected, next_proxResult;
  logic next_proxResultValid, next_proxLogic, next_ambFlag, next_proxFlag;
  logic next_ambientIntN, next_proxIntN, next_intPinN;
  logic proxOutside, proxFire, ambFire;
  lpti_out_mode_t outMode;

  // elaboration checks against the register layout
  if (PROX_WIDTH != 11)
  begin
    $error("lpti_top: PROX_WIDTH must be 11 to match the register layout");
  end
  if (PERSIST_WIDTH != 4)
  begin
    $error("lpti_top: PERSIST_WIDTH must be 4 to match the field layout");
  end

  // register map decode, unused high bits stored as zero, reserved bit 3 stored as written
  always_comb
  begin
    next_intCfg = intCfg;
    next_persist = persist;
    next_upLo = upLo;
    next_upHi = upHi;
    next_lowLo = lowLo;
    next_lowHi = lowHi;
    next_ofsLo = ofsLo;
    next_ofsHi = ofsHi;
    if (regWrite)
    begin
      unique case (regAddr)
        `LPTI_ADDR_INT_CFG: next_intCfg = {2'b00, regWrData[5:0]};
        `LPTI_ADDR_PERSIST: next_persist = regWrData;
        `LPTI_ADDR_UP_LO: next_upLo = regWrData;
        `LPTI_ADDR_UP_HI: next_upHi = {5'h00, regWrData[`LPTI_HI_MSB:0]}; // R08
        `LPTI_ADDR_LOW_LO: next_lowLo = regWrData;
        `LPTI_ADDR_LOW_HI: next_lowHi = {5'h00, regWrData[`LPTI_HI_MSB:0]}; // R09
        `LPTI_ADDR_OFS_LO: next_ofsLo = regWrData;
        `LPTI_ADDR_OFS_HI: next_ofsHi = {5'h00, regWrData[`LPTI_HI_MSB:0]}; // R11
        default: ;
      endcase
    end
    next_regRdData = regRdData;
    if (regRead)
    begin
      unique case (regAddr)
        `LPTI_ADDR_INT_CFG: next_regRdData = intCfg;
        `LPTI_ADDR_PERSIST: next_regRdData = persist;
        `LPTI_ADDR_UP_LO: next_regRdData = upLo;
        `LPTI_ADDR_UP_HI: next_regRdData = upHi;
        `LPTI_ADDR_LOW_LO: next_regRdData = lowLo;
        `LPTI_ADDR_LOW_HI: next_regRdData = lowHi;
        `LPTI_ADDR_OFS_LO: next_regRdData = ofsLo;
        `LPTI_ADDR_OFS_HI: next_regRdData = ofsHi;
        default: next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      intCfg <= `LPTI_RST_INT_CFG;
      persist <= `LPTI_RST_PERSIST;
      upLo <= `LPTI_RST_UP_LO; // R08
      upHi <= `LPTI_RST_UP_HI; // R08
      lowLo <= `LPTI_RST_LOW_LO; // R09
      lowHi <= `LPTI_RST_LOW_HI; // R09
      ofsLo <= `LPTI_RST_OFS_LO; // R11
      ofsHi <= `LPTI_RST_OFS_HI; // R11
      regRdData <= 8'h00;
    end
    else if (clkEn)
    begin
      intCfg <= next_intCfg;
      persist <= next_persist;
      upLo <= next_upLo;
      upHi <= next_upHi;
      lowLo <= next_lowLo;
      lowHi <= next_lowHi;
      ofsLo <= next_ofsLo;
      ofsHi <= next_ofsHi;
      regRdData <= next_regRdData;
    end
  end

  assign upLimit = {upHi[`LPTI_HI_MSB:0], upLo};
  assign lowLimit = {lowHi[`LPTI_HI_MSB:0], lowLo};
  assign offset = {ofsHi[`LPTI_HI_MSB:0], ofsLo}; // R11
  assign outMode = intCfg[`LPTI_CFG_OUT_MODE] ? LPTI_MODE_LOGIC : LPTI_MODE_LATCHED;

  // crosstalk removal with floor at zero
  assign corrected = (proxRaw > offset) ? (proxRaw - offset) : '0; // R10 R17
  assign proxOutside = (corrected > upLimit) || (corrected < lowLimit); // R07

  lpti_persist #(
    .CNT_WIDTH(PERSIST_WIDTH)
  ) u_prox_persist (
    .mclk(mclk),
    .resetn(resetn),
    .clkEn(clkEn),
    .sample(proxRawValid),
    .outside(proxOutside),
    .limit(persist[`LPTI_PERSIST_PROX_MSB:`LPTI_PERSIST_PROX_LSB]), // R06
    .fire(proxFire)
  );

  lpti_persist #(
    .CNT_WIDTH(PERSIST_WIDTH)
  ) u_amb_persist (
    .mclk(mclk),
    .resetn(resetn),
    .clkEn(clkEn),
    .sample(ambientValid),
    .outside(ambientOutside),
    .limit(persist[`LPTI_PERSIST_AMB_MSB:`LPTI_PERSIST_AMB_LSB]), // R05
    .fire(ambFire)
  );

  always_comb
  begin
    next_proxResultValid = proxRawValid;
    next_proxResult = proxResult;
    next_proxLogic = proxLogic;
    if (proxRawValid)
    begin
      next_proxResult = corrected; // R10
      if (corrected < lowLimit)
        next_proxLogic = 1'b0; // R15
      else if (corrected > upLimit)
        next_proxLogic = 1'b1; // R15
    end
    // a new event in the clearing cycle wins over the clear
    next_ambFlag = ambFire ? 1'b1 : (statusRead ? 1'b0 : ambientIntFlag); // R14
    next_proxFlag = proxFire ? 1'b1 : (statusRead ? 1'b0 : proxIntFlag); // R14
    next_ambientIntN = !(next_ambFlag && intCfg[`LPTI_CFG_AMB_EN]); // R01 R12
    next_proxIntN = !(next_proxFlag && intCfg[`LPTI_CFG_PROX_EN]); // R13 R12
    next_intPinN = intPinN;
    unique case (outMode)
      LPTI_MODE_LATCHED: next_intPinN = next_ambientIntN && next_proxIntN; // R02
      LPTI_MODE_LOGIC:
      begin
        if (proxRawValid)
          next_intPinN = !next_proxLogic; // R03 R12
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      proxResultValid <= 1'b0;
      proxResult <= '0;
      proxLogic <= 1'b0;
      ambientIntFlag <= 1'b0;
      proxIntFlag <= 1'b0;
      ambientIntN <= 1'b1;
      proxIntN <= 1'b1;
      intPinN <= 1'b1;
    end
    else if (clkEn)
    begin
      proxResultValid <= next_proxResultValid;
      proxResult <= next_proxResult;
      proxLogic <= next_proxLogic;
      ambientIntFlag <= next_ambFlag;
      proxIntFlag <= next_proxFlag;
      ambientIntN <= next_ambientIntN;
      proxIntN <= next_proxIntN;
      intPinN <= next_intPinN;
    end
  end
endmodule

// ### dv/lpti_top_sva.sv
// port assertions for the threshold interrupt block
// assumes bind to lpti_top, single clock domain
`timescale 1ns/1ns
module lpti_top_sva
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic statusRead,
  input wire logic proxRawValid,
  input wire logic ambientValid,
  input wire logic proxResultValid,
  input wire logic proxLogic,
  input wire logic ambientIntFlag,
  input wire logic proxIntFlag,
  input wire logic ambientIntN,
  input wire logic proxIntN,
  input wire logic intPinN
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_meas;
    clkEn && proxRawValid;
  endsequence
  sequence s_quiet;
    !proxRawValid && !ambientValid && !statusRead;
  endsequence
  property p_result;
    s_meas |=> proxResultValid;
  endproperty
  a_result: assert property (p_result) else $error("no stored result");
  property p_noResult;
    clkEn && !proxRawValid |=> !proxResultValid;
  endproperty
  a_noResult: assert property (p_noResult) else $error("stray result");
  property p_clear;
    clkEn && statusRead && !proxRawValid && !ambientValid |=> !proxIntFlag && !ambientIntFlag;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept after status read");
  property p_hold;
    s_quiet |=> $stable(proxIntFlag) && $stable(ambientIntFlag);
  endproperty
  a_hold: assert property (p_hold) else $error("flag moved without cause");
  property p_proxN;
    !proxIntN |-> proxIntFlag;
  endproperty
  a_proxN: assert property (p_proxN) else $error("prox pin without flag");
  property p_ambN;
    !ambientIntN |-> ambientIntFlag;
  endproperty
  a_ambN: assert property (p_ambN) else $error("ambient pin without flag");
  property p_pin;
    !intPinN |-> proxIntFlag || ambientIntFlag || proxLogic;
  endproperty
  a_pin: assert property (p_pin) else $error("pin low without cause");
  property p_logic;
    !proxRawValid |=> $stable(proxLogic);
  endproperty
  a_logic: assert property (p_logic) else $error("logic moved between samples");
endmodule
bind lpti_top lpti_top_sva i_lpti_top_sva (.*);

// ### dv/lpti_host.sv
// host model: register writes, reads and status reads
// assumes strobes taken at the edge after they are set
`timescale 1ns/1ns
`include "lpti_defines.svh"
module lpti_host
(
  input wire logic mclk,
  input wire logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  output logic statusRead
);
  initial
  begin
    {regAddr, regWrData, regWrite, regRead, statusRead} = '0;
  end
  task automatic pulse(input int k);
    @(posedge mclk);
    regWrite <= (k == 0);
    regRead <= (k == 1);
    statusRead <= (k == 2);
    @(posedge mclk);
    {regWrite, regRead, statusRead} <= 3'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    // source field kept at 01, reserved bit low
    regWrData <= (a == `LPTI_ADDR_INT_CFG) ? {4'h1, 1'b0, d[2:0]} : d;
    pulse(0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    pulse(1);
    @(posedge mclk);
    #1;
    d = regRdData;
  endtask
endmodule

// ### dv/test_light_prox_threshold_interrupt.sv
// self-checking bench for lpti_top
// assumes lpti_host drives the register port
`timescale 1ns/1ns
`include "lpti_defines.svh"
module test_light_prox_threshold_interrupt
  import lpti_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, proxRawValid = 1'b0, ambientValid = 1'b0;
  logic ambientOutside = 1'b0, clkEn = 1'b1;
  logic regWrite, regRead, statusRead, proxResultValid, proxLogic;
  logic ambientIntFlag, proxIntFlag, ambientIntN, proxIntN, intPinN;
  logic [7:0] regAddr, regWrData, regRdData, v;
  logic [10:0] proxRaw = 11'h000, proxResult;
  logic [32:0] rows [5] = '{{11'h0, 11'h123, 11'h123}, {11'h105, 11'h300, 11'h1fb},
    {11'h7ff, 11'h7fe, 11'h0}, {11'h10, 11'h10, 11'h0}, {11'h1, 11'h7ff, 11'h7fe}};
  logic [7:0] rst [9] = '{`LPTI_RST_INT_CFG, `LPTI_RST_PERSIST, `LPTI_RST_UP_LO,
    `LPTI_RST_UP_HI, `LPTI_RST_LOW_LO, `LPTI_RST_LOW_HI, `LPTI_RST_OFS_LO, `LPTI_RST_OFS_HI, 8'h00};
  logic [10:0] pat [6] = '{11'h065, 11'h013, 11'h064, 11'h065, 11'h013, 11'h065};
  int failCount = 0, nChecks = 0;
  lpti_top i_lpti_top (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .statusRead(statusRead), .proxRawValid(proxRawValid), .proxRaw(proxRaw),
    .ambientValid(ambientValid), .ambientOutside(ambientOutside),
    .proxResultValid(proxResultValid), .proxResult(proxResult), .proxLogic(proxLogic),
    .ambientIntFlag(ambientIntFlag), .proxIntFlag(proxIntFlag), .ambientIntN(ambientIntN),
    .proxIntN(proxIntN), .intPinN(intPinN));
  lpti_host i_lpti_host (.mclk(mclk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .statusRead(statusRead));
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    nChecks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      failCount++;
    end
  endtask
  task automatic meas(input logic p, input logic [10:0] r, input logic a);
    @(posedge mclk);
    proxRawValid <= p;
    proxRaw <= r;
    ambientValid <= a;
    ambientOutside <= 1'b1;
    @(posedge mclk);
    {proxRawValid, ambientValid, ambientOutside} <= 3'h0;
    proxRaw <= ~r;
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      i_lpti_host.rd((i < 8) ? 8'h19 + 8'(i) : 8'h40, v);
      chk("reg", rst[i], v);
    end
    $display("reset test done");
    for (int i = 0; i < 5; i++)
    begin
      i_lpti_host.wr(8'h1f, rows[i][29:22]);
      i_lpti_host.wr(8'h20, {5'h0, rows[i][32:30]});
      meas(1'b1, rows[i][21:11], 1'b0);
      chk("result", rows[i][10:0], proxResult);
      chk("valid", 1'b1, proxResultValid);
    end
    $display("offset table done");
    i_lpti_host.wr(8'h20, 8'hff);
    i_lpti_host.rd(8'h20, v);
    chk("ofs_hi", 8'h07, v);
    i_lpti_host.wr(8'h1f, 8'h0);
    i_lpti_host.wr(8'h20, 8'h0);
    i_lpti_host.wr(8'h1a, 8'h12);
    i_lpti_host.wr(8'h1b, 8'h64);
    i_lpti_host.wr(8'h1c, 8'hf8);
    i_lpti_host.wr(8'h1d, 8'h14);
    i_lpti_host.wr(8'h19, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      meas(1'b1, pat[i], 1'b0);
      chk("proxFlag", i == 5, proxIntFlag);
    end
    chk("proxN", 1'b0, proxIntN);
    chk("pin", 1'b0, intPinN);
    meas(1'b0, 11'h0, 1'b1);
    chk("ambFlag", 1'b0, ambientIntFlag);
    meas(1'b0, 11'h0, 1'b1);
    chk("ambFlag", 1'b1, ambientIntFlag);
    chk("ambN", 1'b1, ambientIntN);
    i_lpti_host.wr(8'h19, 8'h05);
    meas(1'b0, 11'h0, 1'b1);
    chk("ambN", 1'b0, ambientIntN);
    i_lpti_host.pulse(2);
    #1;
    chk("flags", 2'b00, {proxIntFlag, ambientIntFlag});
    chk("pin", 1'b1, intPinN);
    $display("persistence test done");
    i_lpti_host.wr(8'h19, 8'h03);
    meas(1'b1, 11'h013, 1'b0);
    chk("logic", 2'b01, {proxLogic, intPinN});
    meas(1'b1, 11'h065, 1'b0);
    chk("logic", 2'b10, {proxLogic, intPinN});
    meas(1'b1, 11'h032, 1'b0);
    chk("logic", 2'b10, {proxLogic, intPinN});
    i_lpti_host.pulse(2);
    #1;
    chk("pin", 1'b0, intPinN);
    $display("logic mode test done");
    // a measurement while the enable is low must leave every output frozen
    @(posedge mclk);
    clkEn <= 1'b0;
    meas(1'b1, 11'h013, 1'b0);
    chk("frozenValid", 1'b0, proxResultValid);
    chk("frozenLogic", 2'b10, {proxLogic, intPinN});
    @(posedge mclk);
    clkEn <= 1'b1;
    $display("clock enable test done");
    // reset in mid-run returns pin, logic signal and limits to defaults
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rstPin", 1'b1, intPinN);
    chk("rstLogic", 1'b0, proxLogic);
    @(posedge mclk);
    resetn <= 1'b1;
    i_lpti_host.rd(8'h1b, v);
    chk("upLo", 8'hff, v);
    $display("mid-run reset test done");
    complete_run();
  end
endmodule
